//--- common/rpu_consts.svh
// Offsets, field positions and reset values of the region protection unit
`ifndef RPU_CONSTS_SVH
`define RPU_CONSTS_SVH

// Controller registers on APB (byte addresses)
`define RPU_OFF_CTRL      12'h000
`define RPU_OFF_BASE      12'h004
`define RPU_OFF_ACC       12'h008
`define RPU_OFF_REQ_ADDR  12'h00C
`define RPU_OFF_REQ_CTL   12'h010
`define RPU_OFF_STATUS    12'h014

// Region base word
`define RPU_BASE_HI       31
`define RPU_BASE_LO       8
`define RPU_INDEX_HI      5
`define RPU_INDEX_LO      1
`define RPU_TYPE_BIT      0

// Region access word
`define RPU_MASK_LO       8
`define RPU_LIMIT_LO      7
`define RPU_CACHE_BIT     5
`define RPU_PERM_HI       4
`define RPU_PERM_LO       2
`define RPU_RD_BIT        1
`define RPU_WR_BIT        0

// Granule is 256 bytes: address bits below this are ignored
`define RPU_GRAN_BITS     8

// Request control and status fields
`define RPU_KIND_HI       1
`define RPU_KIND_LO       0
`define RPU_USER_BIT      2
`define RPU_DONE_BIT      0
`define RPU_FAULT_BIT     1
`define RPU_CACHED_BIT    2

`define RPU_WORD_RESET    32'h0000_0000

`endif

//--- common/rpu_if.sv
// Link between the processor core side and the protection unit
`timescale 1ns/1ps
interface rpu_if;
    logic                cfg_we;
    rpu_pkg::rpu_sel_t   cfg_sel;
    logic [31:0]         cfg_wdata;
    logic [31:0]         base_q;
    logic [31:0]         acc_q;
    logic                enable_q;
    logic                req_valid;
    logic [31:0]         req_addr;
    rpu_pkg::rpu_kind_t  req_kind;
    logic                req_user;
    logic                resp_valid;
    logic                resp_fault;
    logic                resp_cache;

    modport dev (
        input  cfg_we, cfg_sel, cfg_wdata, req_valid, req_addr, req_kind,
               req_user,
        output base_q, acc_q, enable_q, resp_valid, resp_fault, resp_cache
    );
    modport core (
        output cfg_we, cfg_sel, cfg_wdata, req_valid, req_addr, req_kind,
               req_user,
        input  base_q, acc_q, enable_q, resp_valid, resp_fault, resp_cache
    );
endinterface

//--- common/rpu_pkg.sv
// Types shared by both ends of the region protection unit
package rpu_pkg;

    typedef enum logic [1:0] {
        RPU_FETCH,
        RPU_LOAD,
        RPU_STORE
    } rpu_kind_t;

    typedef enum logic [1:0] {
        RPU_SEL_CTRL,
        RPU_SEL_BASE,
        RPU_SEL_ACC
    } rpu_sel_t;

    typedef enum logic {
        RPU_IDLE,
        RPU_WAIT
    } rpu_req_state_t;

endpackage

//--- logic/rpu_device.sv
// Region protection unit: region table, access checks and register pair
//
// Summary of operation
// - Mask field is ones shifted by log2 size
// - Limit is first granule past region top
// - Data regions carry a cacheable flag
// - Instruction permission codes 000, 001, 010 decoded
// - Data permission codes 000-110 decoded
// - Read command loads entry into register pair
// - Write command stores register pair into entry
// - Software never sets read and write together
// - Software disables mask regions: nonzero base, 4GB
// - Limit zero with nonzero base never matches
// - Unit comes out of reset disabled
// - Software rewrites regions only while unit off
// - Software re-enables unit before guarded code
// - Software uses power-of-two sizes, aligned bases
// - Overlaps resolved by highest-priority matching region
// - Access hitting no region raises a fault while unit on
// - Denied permission raises a fault while unit on
// - Mask or limit sizing chosen at build time
// - Lower region number has higher priority
// - Type bit selects data or instruction region
// - Base field is start address over granule
`timescale 1ns/1ps
`include "rpu_consts.svh"
module rpu_device #(
    parameter int N_REG     = 8,
    parameter bit USE_LIMIT = 1'b0
) (
    input  wire logic clock,
    input  wire logic rst,
    rpu_if.dev        link,
    output logic      unit_on,
    output logic      fault_seen
);
    localparam int IW = (N_REG > 1) ? $clog2(N_REG) : 1;
    localparam int AW = 32 - `RPU_GRAN_BITS;

    // Index field is five bits wide, so more entries cannot be reached
    if (N_REG < 1 || N_REG > 32) begin : g_bad_n_reg
        $error("N_REG must lie between 1 and 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // Region table, one set for instructions (0) and one for data (1)
    logic [AW-1:0] ent_base  [2][N_REG];
    logic [AW:0]   ent_size  [2][N_REG];
    logic [2:0]    ent_perm  [2][N_REG];
    logic          ent_cache [2][N_REG];

    logic [AW-1:0] base_field;
    logic [4:0]    index_field;
    logic          type_field;
    logic [AW:0]   size_field;
    logic [2:0]    perm_field;
    logic          cache_field;
    logic          enabled;

    logic          acc_write;
    logic          cmd_rd;
    logic          cmd_wr;
    logic [AW:0]   wr_size;
    logic [IW-1:0] sel_idx;
    logic          idx_ok;

    assign acc_write = link.cfg_we && link.cfg_sel == rpu_pkg::RPU_SEL_ACC;
    assign cmd_rd    = acc_write && link.cfg_wdata[`RPU_RD_BIT]
                       && !link.cfg_wdata[`RPU_WR_BIT];
    assign cmd_wr    = acc_write && link.cfg_wdata[`RPU_WR_BIT];
    assign sel_idx   = IW'(index_field);
    assign idx_ok    = 32'(index_field) < N_REG;

    // Size field as carried by the access word for the chosen sizing
    always_comb begin
        if (USE_LIMIT) begin
            wr_size = link.cfg_wdata[31:`RPU_LIMIT_LO];
        end else begin
            wr_size = {1'b0, link.cfg_wdata[31:`RPU_MASK_LO]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Base word: written by software, reloaded by a region read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            base_field  <= '0;
            index_field <= '0;
            type_field  <= 1'b0;
        end else if (link.cfg_we && link.cfg_sel == rpu_pkg::RPU_SEL_BASE)
        begin
            base_field  <= link.cfg_wdata[`RPU_BASE_HI:`RPU_BASE_LO];
            index_field <= link.cfg_wdata[`RPU_INDEX_HI:`RPU_INDEX_LO];
            type_field  <= link.cfg_wdata[`RPU_TYPE_BIT];
        end else if (cmd_rd && idx_ok) begin
            base_field <= ent_base[type_field][sel_idx];
        end
    end

    // Access word fields; the command bits are never stored
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            size_field  <= '0;
            perm_field  <= '0;
            cache_field <= 1'b0;
        end else if (cmd_rd) begin
            if (idx_ok) begin
                size_field  <= ent_size[type_field][sel_idx];
                perm_field  <= ent_perm[type_field][sel_idx];
                cache_field <= ent_cache[type_field][sel_idx];
            end
        end else if (acc_write) begin
            size_field  <= wr_size;
            perm_field  <= link.cfg_wdata[`RPU_PERM_HI:`RPU_PERM_LO];
            cache_field <= link.cfg_wdata[`RPU_CACHE_BIT];
        end
    end

    // A write command takes the access fields of the same bus write,
    // so one write both loads and commits the entry
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int t = 0; t < 2; t++) begin
                for (int r = 0; r < N_REG; r++) begin
                    ent_base[t][r]  <= '0;
                    ent_size[t][r]  <= '0;
                    ent_perm[t][r]  <= '0;
                    ent_cache[t][r] <= 1'b0;
                end
            end
        end else if (cmd_wr && idx_ok) begin
            ent_base[type_field][sel_idx]  <= base_field;
            ent_size[type_field][sel_idx]  <= wr_size;
            ent_perm[type_field][sel_idx]  <=
                link.cfg_wdata[`RPU_PERM_HI:`RPU_PERM_LO];
            ent_cache[type_field][sel_idx] <=
                link.cfg_wdata[`RPU_CACHE_BIT];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enabled <= 1'b0;
        end else if (link.cfg_we && link.cfg_sel == rpu_pkg::RPU_SEL_CTRL)
        begin
            enabled <= link.cfg_wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address matching, one comparator per entry and region type
    logic [AW-1:0] gran_addr;
    logic [N_REG-1:0] hit [2];

    assign gran_addr = link.req_addr[31:`RPU_GRAN_BITS];

    for (genvar t = 0; t < 2; t++) begin : g_type
        for (genvar r = 0; r < N_REG; r++) begin : g_ent
            logic [AW-1:0] m;
            assign m = ent_size[t][r][AW-1:0];
            if (USE_LIMIT) begin : g_lim
                // Limit 0 can never exceed the address: region is off
                assign hit[t][r] = {1'b0, gran_addr} >= {1'b0, ent_base[t][r]}
                    && {1'b0, gran_addr} < ent_size[t][r];
            end else begin : g_msk
                // A base with bits under the mask is misaligned and is
                // how software switches a region off
                assign hit[t][r] = ((gran_addr ^ ent_base[t][r]) & m) == '0
                    && (ent_base[t][r] & ~m) == '0;
            end
        end
    end

    // Lowest-numbered matching entry wins
    logic          any_hit;
    logic [IW-1:0] win;
    logic          is_data;

    assign is_data = link.req_kind != rpu_pkg::RPU_FETCH;

    always_comb begin
        any_hit = 1'b0;
        win     = '0;
        for (int r = N_REG - 1; r >= 0; r--) begin
            if (hit[is_data][r]) begin
                any_hit = 1'b1;
                win     = IW'(r);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Permission decode
    logic [2:0] p;
    logic       allowed;

    assign p = ent_perm[is_data][win];

    always_comb begin
        allowed = 1'b0;
        case (link.req_kind)
            rpu_pkg::RPU_FETCH: begin
                allowed = link.req_user ? (p == 3'h2)
                                        : (p == 3'h1 || p == 3'h2);
            end
            rpu_pkg::RPU_LOAD: begin
                allowed = link.req_user
                    ? (p == 3'h2 || p == 3'h5 || p == 3'h6)
                    : (p == 3'h1 || p == 3'h2 || p == 3'h4
                       || p == 3'h5 || p == 3'h6);
            end
            rpu_pkg::RPU_STORE: begin
                allowed = link.req_user
                    ? (p == 3'h6)
                    : (p == 3'h4 || p == 3'h5 || p == 3'h6);
            end
            default: begin
                allowed = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Answer one cycle after each request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.resp_valid <= 1'b0;
            link.resp_fault <= 1'b0;
            link.resp_cache <= 1'b0;
        end else begin
            link.resp_valid <= link.req_valid;
            if (link.req_valid) begin
                if (!enabled) begin
                    link.resp_fault <= 1'b0;
                    link.resp_cache <= 1'b0;
                end else begin
                    link.resp_fault <= !any_hit || !allowed;
                    link.resp_cache <= any_hit && is_data
                                       && ent_cache[1][win];
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_seen <= 1'b0;
        end else begin
            fault_seen <= link.req_valid && enabled
                          && (!any_hit || !allowed);
        end
    end

    // Readback words
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.enable_q <= 1'b0;
            unit_on       <= 1'b0;
            link.base_q   <= `RPU_WORD_RESET;
            link.acc_q    <= `RPU_WORD_RESET;
        end else begin
            link.enable_q <= enabled;
            unit_on       <= enabled;
            link.base_q   <= {base_field, 2'b00, index_field, type_field};
            if (USE_LIMIT) begin
                link.acc_q <= {size_field, 1'b0, cache_field,
                               perm_field, 2'b00};
            end else begin
                link.acc_q <= {size_field[AW-1:0], 2'b00, cache_field,
                               perm_field, 2'b00};
            end
        end
    end

endmodule

//--- logic/rpu_host.sv
// Processor core side: APB controller that configures and exercises the unit
`timescale 1ns/1ps
`include "rpu_consts.svh"
module rpu_host (
    input  wire logic        clock,
    input  wire logic        rst,
    rpu_if.core              link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    logic        setup;
    logic        wr_done;
    logic        mapped;
    logic [31:0] req_ctl;
    logic        done;
    logic        fault;
    logic        cached;
    rpu_pkg::rpu_req_state_t state;

    assign setup   = psel && !penable;
    assign wr_done = psel && penable && pready && pwrite;

    always_comb begin
        if (paddr == `RPU_OFF_CTRL) begin
            mapped = 1'b1;
        end else if (paddr == `RPU_OFF_BASE) begin
            mapped = 1'b1;
        end else if (paddr == `RPU_OFF_ACC) begin
            mapped = 1'b1;
        end else if (paddr == `RPU_OFF_REQ_ADDR) begin
            mapped = 1'b1;
        end else if (paddr == `RPU_OFF_REQ_CTL) begin
            mapped = 1'b1;
        end else if (paddr == `RPU_OFF_STATUS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: one wait-free access phase, data captured at setup
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `RPU_WORD_RESET;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                if (paddr == `RPU_OFF_CTRL) begin
                    prdata <= {31'h0, link.enable_q};
                end else if (paddr == `RPU_OFF_BASE) begin
                    prdata <= link.base_q;
                end else if (paddr == `RPU_OFF_ACC) begin
                    prdata <= link.acc_q;
                end else if (paddr == `RPU_OFF_REQ_ADDR) begin
                    prdata <= link.req_addr;
                end else if (paddr == `RPU_OFF_REQ_CTL) begin
                    prdata <= req_ctl;
                end else if (paddr == `RPU_OFF_STATUS) begin
                    prdata <= {29'h0, cached, fault, done};
                end else begin
                    prdata <= `RPU_WORD_RESET;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration writes are forwarded as one-cycle strobes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.cfg_we    <= 1'b0;
            link.cfg_sel   <= rpu_pkg::RPU_SEL_CTRL;
            link.cfg_wdata <= `RPU_WORD_RESET;
        end else begin
            link.cfg_we <= wr_done && (paddr == `RPU_OFF_CTRL
                || paddr == `RPU_OFF_BASE || paddr == `RPU_OFF_ACC);
            if (wr_done) begin
                link.cfg_wdata <= pwdata;
                if (paddr == `RPU_OFF_BASE) begin
                    link.cfg_sel <= rpu_pkg::RPU_SEL_BASE;
                end else if (paddr == `RPU_OFF_ACC) begin
                    link.cfg_sel <= rpu_pkg::RPU_SEL_ACC;
                end else begin
                    link.cfg_sel <= rpu_pkg::RPU_SEL_CTRL;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trial access: launched by a write of the request control word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.req_addr <= `RPU_WORD_RESET;
            req_ctl       <= `RPU_WORD_RESET;
        end else if (wr_done && paddr == `RPU_OFF_REQ_ADDR) begin
            link.req_addr <= pwdata;
        end else if (wr_done && paddr == `RPU_OFF_REQ_CTL) begin
            req_ctl <= {29'h0, pwdata[`RPU_USER_BIT:0]};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state          <= rpu_pkg::RPU_IDLE;
            link.req_valid <= 1'b0;
            link.req_kind  <= rpu_pkg::RPU_FETCH;
            link.req_user  <= 1'b0;
        end else begin
            link.req_valid <= 1'b0;
            case (state)
                rpu_pkg::RPU_IDLE: begin
                    // A launch while waiting is ignored: one in flight
                    if (wr_done && paddr == `RPU_OFF_REQ_CTL) begin
                        link.req_valid <= 1'b1;
                        link.req_kind  <= rpu_pkg::rpu_kind_t'(
                            pwdata[`RPU_KIND_HI:`RPU_KIND_LO]);
                        link.req_user  <= pwdata[`RPU_USER_BIT];
                        state          <= rpu_pkg::RPU_WAIT;
                    end
                end
                rpu_pkg::RPU_WAIT: begin
                    if (link.resp_valid) begin
                        state <= rpu_pkg::RPU_IDLE;
                    end
                end
                default: begin
                    state <= rpu_pkg::RPU_IDLE;
                end
            endcase
        end
    end

    // Answer beats a clearing launch in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done   <= 1'b0;
            fault  <= 1'b0;
            cached <= 1'b0;
        end else if (link.resp_valid) begin
            done   <= 1'b1;
            fault  <= link.resp_fault;
            cached <= link.resp_cache;
        end else if (wr_done && paddr == `RPU_OFF_REQ_CTL
                     && state == rpu_pkg::RPU_IDLE) begin
            done <= 1'b0;
        end
    end

endmodule

//--- tb/rpu_checker_sva.sv
// Concurrent checks on the link between core side and protection unit
`timescale 1ns/1ps
module rpu_checker (
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               cfg_we,
    input wire rpu_pkg::rpu_sel_t  cfg_sel,
    input wire logic [31:0]        cfg_wdata,
    input wire logic [31:0]        base_q,
    input wire logic [31:0]        acc_q,
    input wire logic               enable_q,
    input wire logic               req_valid,
    input wire rpu_pkg::rpu_kind_t req_kind,
    input wire logic               resp_valid,
    input wire logic               resp_fault,
    input wire logic               resp_cache
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    logic cfg_ctrl;
    logic cfg_base;
    // The readback lags the enable state, so one cycle after a write is unsure
    assign cfg_ctrl = cfg_we && cfg_sel == rpu_pkg::RPU_SEL_CTRL;
    assign cfg_base = cfg_we && cfg_sel == rpu_pkg::RPU_SEL_BASE;

    ////////////////////////////////////////////////////////////////////////
    chk_resp_one_later: assert property (req_valid |=> resp_valid)
        else $error("answer missing one cycle after request");
    chk_resp_only_req: assert property (!req_valid |=> !resp_valid)
        else $error("answer without request");
    chk_off_bypass: assert property (req_valid && !enable_q && !cfg_ctrl
        && !$past(cfg_ctrl) |=> !resp_fault && !resp_cache)
        else $error("check made while unit disabled");
    chk_stays_off: assert property (!enable_q && !cfg_ctrl
        && !$past(cfg_ctrl) |=> !enable_q)
        else $error("unit enabled without a control write");
    chk_enable_follow: assert property (cfg_ctrl
        |-> ##2 enable_q == $past(cfg_wdata[0], 2))
        else $error("enable does not follow control write");
    chk_fetch_uncached: assert property (req_valid
        && req_kind == rpu_pkg::RPU_FETCH |=> !resp_cache)
        else $error("fetch answered cacheable");
    chk_cmd_bits_zero: assert property (acc_q[1:0] == 2'b00)
        else $error("command bits read back nonzero");
    chk_base_fields: assert property (cfg_base |-> ##2
        (base_q & 32'hFFFF_FF01) == ($past(cfg_wdata, 2) & 32'hFFFF_FF01))
        else $error("base readback differs from write");
    chk_resp_held: assert property (!resp_valid
        |-> $stable(resp_fault) && $stable(resp_cache))
        else $error("answer flags moved between answers");

    cover property (resp_valid && resp_fault);
    cover property (resp_valid && resp_cache);
    cover property ($rose(enable_q));
endmodule

//--- tb/testbench.sv
// Self-checking bench: APB stimulus into the core side, unit as far end
`timescale 1ns/1ps
`include "rpu_consts.svh"
module testbench;
    logic        clock;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        unit_on;
    logic        fault_seen;
    logic        want_fault;
    logic [31:0] rd;
    logic        err;
    int          bad_count;
    int          compares;

    rpu_if link ();
    rpu_device u_rpu_device (.clock(clock), .rst(rst), .link(link),
        .unit_on(unit_on), .fault_seen(fault_seen));
    rpu_host u_rpu_host (.clock(clock), .rst(rst), .link(link),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    rpu_checker u_rpu_checker (.clock(clock), .rst(rst),
        .cfg_we(link.cfg_we), .cfg_sel(link.cfg_sel),
        .cfg_wdata(link.cfg_wdata), .base_q(link.base_q),
        .acc_q(link.acc_q), .enable_q(link.enable_q),
        .req_valid(link.req_valid), .req_kind(link.req_kind),
        .resp_valid(link.resp_valid), .resp_fault(link.resp_fault),
        .resp_cache(link.resp_cache));

    always #20 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Reads wait for the readback words, which trail a write by two cycles
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        if (!wr) repeat (3) @(posedge clock);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic region(input logic [4:0] idx, input logic d,
                          input logic [23:0] base, input logic [23:0] mask,
                          input logic c, input logic [2:0] perm);
        apb(1'b1, `RPU_OFF_BASE, {base, 2'b00, idx, d});
        apb(1'b1, `RPU_OFF_ACC, {mask, 2'b00, c, perm, 2'b01});
    endtask

    // Cache flag is only meaningful on an access that was let through
    task automatic access(input logic [31:0] a, input logic [1:0] k,
                          input logic u, input logic f, input logic c);
        int n;
        want_fault = f;
        apb(1'b1, `RPU_OFF_REQ_ADDR, a);
        apb(1'b1, `RPU_OFF_REQ_CTL, {29'h0, u, k});
        n = 0;
        do begin
            apb(1'b0, `RPU_OFF_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 20);
        check("status", {29'h0, rd[2:0] & {~f, 2'b11}},
              {29'h0, c & ~f, f, 1'b1});
    endtask

    function automatic logic allow(input logic d, input logic [2:0] p,
                                   input logic st, input logic u);
        if (!d) return p == 3'b010 || (p == 3'b001 && !u);
        case (p)
            3'b001: return !u && !st;
            3'b010: return !st;
            3'b100: return !u;
            3'b101: return !u || !st;
            3'b110: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Fault pulse must agree with the answer it belongs to
    always @(negedge clock) begin
        if (link.resp_valid) begin
            check("fault_seen", {31'h0, fault_seen}, {31'h0, want_fault});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        bad_count = 0;
        compares = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, `RPU_OFF_CTRL, 32'h0);
        check("ctrl", rd, 32'h0);
        check("unit_on", {31'h0, unit_on}, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        access(32'h0003_0000, 2'd2, 1'b1, 1'b0, 1'b0);
        region(5'd0, 1'b1, 24'h10, 24'hFFFFF0, 1'b1, 3'b101);
        region(5'd1, 1'b1, 24'h0, 24'hFFFF00, 1'b0, 3'b110);
        region(5'd2, 1'b1, 24'h300, 24'h0, 1'b1, 3'b110);
        region(5'd0, 1'b0, 24'h10, 24'hFFFFF0, 1'b0, 3'b001);
        region(5'd1, 1'b0, 24'h20, 24'hFFFFF0, 1'b0, 3'b010);
        apb(1'b1, `RPU_OFF_BASE, {24'hAB, 2'b00, 5'd0, 1'b1});
        apb(1'b1, `RPU_OFF_ACC, 32'h2);
        apb(1'b0, `RPU_OFF_BASE, 32'h0);
        check("base", rd, {24'h10, 2'b00, 5'd0, 1'b1});
        apb(1'b0, `RPU_OFF_ACC, 32'h0);
        check("acc", rd, {24'hFFFFF0, 2'b00, 1'b1, 3'b101, 2'b00});
        apb(1'b1, `RPU_OFF_CTRL, 32'h1);
        apb(1'b0, `RPU_OFF_CTRL, 32'h0);
        check("ctrl on", rd, 32'h1);
        check("unit_on", {31'h0, unit_on}, 32'h1);
        access(32'h0000_1004, 2'd1, 1'b1, 1'b0, 1'b1);
        access(32'h0000_1FFC, 2'd2, 1'b1, 1'b1, 1'b0);
        access(32'h0000_2000, 2'd2, 1'b1, 1'b0, 1'b0);
        access(32'h0003_0000, 2'd1, 1'b0, 1'b1, 1'b0);
        access(32'h0000_1000, 2'd0, 1'b0, 1'b0, 1'b0);
        access(32'h0000_1000, 2'd0, 1'b1, 1'b1, 1'b0);
        access(32'h0000_2FFC, 2'd0, 1'b1, 1'b0, 1'b0);
        for (int d = 0; d < 2; d++) begin
            for (int p = 0; p < 8; p++) begin
                apb(1'b1, `RPU_OFF_CTRL, 32'h0);
                // Entry 2: an unused all-space entry below it would win
                region(5'd2, d[0], 24'h400, 24'hFFFFF0, 1'b1, p[2:0]);
                apb(1'b1, `RPU_OFF_CTRL, 32'h1);
                for (int k = 0; k < 3; k++) begin
                    for (int u = 0; u < 2; u++) begin
                        if ((k == 0) == (d == 0))
                            access(32'h0004_0010, k[1:0], u[0],
                                   !allow(d[0], p[2:0], k == 2, u[0]),
                                   d[0]);
                    end
                end
            end
        end
        final_report();
    end

    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        final_report();
    end
endmodule
